// [hdl/tlc_pkg.sv]
package tlc_pkg;

  // system clock, 200 MHz
  localparam int CLK_PERIOD_PS = 5000;

  // pin synchroniser: one bit per pin
  localparam int SYNC_W        = 10;
  localparam int PIN_CLK       = 0;
  localparam int PIN_POS       = 1;
  localparam int PIN_NEG       = 2;
  localparam int PIN_HW_RAIL   = 3;
  localparam int PIN_HOST_RAIL = 4;
  localparam int PIN_HOST_MODE = 5;
  localparam int PIN_HW_RATE   = 6;
  localparam int PIN_HOST_RATE = 8;

  // substitution run lengths and symbol window
  localparam logic [2:0] RUN_B3ZS = 3'h3;
  localparam logic [2:0] RUN_HDB3 = 3'h4;
  localparam int         SLOTS    = 4;

  // fifo in the data path: {positive, negative}
  localparam int FIFO_W = 2;
  localparam int FIFO_D = 8;

  // reset values of the encoder state
  localparam logic       POL_START    = 1'b0;
  localparam logic       PARITY_START = 1'b0;
  localparam logic [2:0] RUN_START    = 3'h0;
  localparam logic [7:0] PERIOD_START = 8'h08;

  // rate strap encoding
  typedef enum logic [1:0] {
    TLC_RATE_E3,
    TLC_RATE_DS3,
    TLC_RATE_STS1,
    TLC_RATE_SPARE
  } tlc_rate_t;

endpackage

// [hdl/tlc_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module tlc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } tlc_fifo_state_t;

  tlc_fifo_state_t q;
  tlc_fifo_state_t d;
  logic            doPush;
  logic            doPop;

  // honest flags straight from the fill count
  assign inReady  = (q.count != (AW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData  = q.mem[q.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // pointer wrap relies on depth being a power of two
  always_comb begin
    d = q;
    if (doPush) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr        = q.wrPtr + 1'b1;
    end
    if (doPop) begin
      d.rdPtr = q.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      d.count = q.count + 1'b1;
    end else if (doPop && !doPush) begin
      d.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_fifo_bounds: assert property (@(posedge clock) disable iff (!rstn)
    q.count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// [hdl/tlc_encoder.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - rate per channel, strap or host
// - single rail: positive input only, negative zero
// - rail select pin or host bit 0
// - dual rail rails forwarded as polarities
// - single rail: B3ZS for DS3/STS-1, HDB3 E3
// - three zeros become B0V or 00V
// - odd mark count between violations
// - marks and B alternate polarity
// - V repeats previous mark polarity
// - accept 30-70% duty, regenerate 50%
// - four zeros become 000V or B00V
// - dual rail bypasses the encoder
// - sample data on clock falling edge
module tlc_encoder
  import tlc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       txLineClock,
  input  wire logic       txPositiveData,
  input  wire logic       txNegativeData,
  input  wire logic       railFormatSelect,
  input  wire logic       hostRailCtrl,
  input  wire logic       hostMode,
  input  wire logic [1:0] hwRateSelect,
  input  wire logic [1:0] hostRateSelect,
  input  wire logic       lineEnable,
  output logic            txReady,
  output logic            linePos,
  output logic            lineNeg,
  output logic            lineClock50,
  output logic            codingActive
);

  typedef struct packed {
    logic [SYNC_W-1:0]       s1;
    logic [SYNC_W-1:0]       s2;
    logic [SYNC_W-1:0]       s3;
    logic [SYNC_W-1:0]       pinStable;
    logic [SLOTS-1:0][2:0]   slot;
    logic [2:0]              zeroRun;
    logic                    lastPol;
    logic                    markParity;
    logic                    outPos;
    logic                    outNeg;
    logic                    outViol;
    logic                    outStrobe;
    logic                    lastOutPol;
    logic                    outParity;
    logic [7:0]              periodCnt;
    logic [7:0]              periodLen;
    logic                    clk50;
  } tlc_state_t;

  tlc_state_t        q;
  tlc_state_t        d;
  logic [SYNC_W-1:0] pinNow;
  logic              clkFall;
  logic              clkRise;
  logic              singleRail;
  tlc_rate_t         rate;
  logic [2:0]        runLimit;
  logic [1:0]        outIdx;
  logic              tick;
  logic              fifoValid;
  logic [1:0]        fifoData;
  logic              dataBit;
  logic              newPol;
  logic [2:0]        nextSym;
  logic [SYNC_W-1:0] pinRaw;

  assign pinRaw = {hostRateSelect, hwRateSelect, hostMode, hostRailCtrl,
                   railFormatSelect, txNegativeData, txPositiveData, txLineClock};

  // a pin change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_agree
      assign pinNow[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.pinStable[gi];
    end
  endgenerate

  // edges of the partner clock, seen through the synchroniser
  assign clkFall = q.pinStable[PIN_CLK] && !pinNow[PIN_CLK];
  assign clkRise = !q.pinStable[PIN_CLK] && pinNow[PIN_CLK];

  // mode choice: host copies when in host mode, straps otherwise
  assign singleRail = pinNow[PIN_HOST_MODE] ? pinNow[PIN_HOST_RAIL]
                                            : pinNow[PIN_HW_RAIL];
  assign rate = tlc_rate_t'(pinNow[PIN_HOST_MODE] ?
                            pinNow[PIN_HOST_RATE +: 2] : pinNow[PIN_HW_RATE +: 2]);
  assign runLimit     = (rate == TLC_RATE_E3) ? RUN_HDB3 : RUN_B3ZS;
  assign outIdx       = 2'(runLimit - 3'h1);
  assign codingActive = singleRail;

  // drain one symbol per line-clock rise; a stopped transmitter back-pressures
  assign tick = clkRise && lineEnable;

  tlc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (clkFall),
    .inReady  (txReady),
    .inData   ({pinNow[PIN_POS], pinNow[PIN_NEG] && !singleRail}),
    .outValid (fifoValid),
    .outReady (tick),
    .outData  (fifoData)
  );

  // an empty fifo on a tick is sent as a zero bit, not a gap
  assign dataBit = fifoValid && fifoData[1];

  // substitution and polarity decision as each bit enters the window
  always_comb begin
    d         = q;
    d.s1      = pinRaw;
    d.s2      = q.s1;
    d.s3      = q.s2;
    d.pinStable = pinNow;
    d.outStrobe = tick;
    newPol    = ~q.lastPol;
    nextSym   = 3'h0;
    if (tick) begin
      d.slot = {q.slot[SLOTS-2:0], 3'h0};
      if (singleRail) begin
        d.outPos  = q.slot[outIdx][1];
        d.outNeg  = q.slot[outIdx][0];
        d.outViol = q.slot[outIdx][2];
        if (dataBit) begin
          nextSym      = {1'b0, newPol, ~newPol};
          d.lastPol    = newPol;
          d.markParity = ~q.markParity;
          d.zeroRun    = RUN_START;
        end else if (q.zeroRun + 3'h1 == runLimit) begin
          if (q.markParity) begin
            // 00V / 000V: odd marks already since the last V
            nextSym = {1'b1, q.lastPol, ~q.lastPol};
          end else begin
            // B00V / B0V: the B makes the count odd
            d.slot[outIdx] = {1'b0, newPol, ~newPol};
            nextSym        = {1'b1, newPol, ~newPol};
            d.lastPol      = newPol;
          end
          d.markParity = 1'b0;
          d.zeroRun    = RUN_START;
        end else begin
          d.zeroRun = q.zeroRun + 3'h1;
        end
        d.slot[0] = nextSym;
      end else begin
        // dual rail: rails go straight to the line, encoder idle
        d.outPos  = fifoValid && fifoData[1];
        d.outNeg  = fifoValid && fifoData[0];
        d.outViol = 1'b0;
      end
    end
    // output-side polarity history, one cycle behind each symbol
    if (q.outStrobe && (q.outPos || q.outNeg)) begin
      d.lastOutPol = q.outPos;
      d.outParity  = q.outViol ? 1'b0 : ~q.outParity;
    end
    // period measured between falls; high for the first half, any input duty
    if (clkFall) begin
      d.periodCnt = 8'h00;
      d.periodLen = (q.periodCnt == 8'hff) ? q.periodCnt : q.periodCnt + 8'h01;
      d.clk50     = 1'b1;
    end else begin
      d.periodCnt = (q.periodCnt == 8'hff) ? q.periodCnt : q.periodCnt + 8'h01;
      // nine bits so a saturated count cannot wrap and hold the clock high
      d.clk50     = ({1'b0, q.periodCnt} + 9'h001) < {2'b00, q.periodLen[7:1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q            <= '0;
      q.lastPol    <= POL_START;
      q.markParity <= PARITY_START;
      q.zeroRun    <= RUN_START;
      q.lastOutPol <= POL_START;
      q.periodLen  <= PERIOD_START;
    end else begin
      q <= d;
    end
  end

  assign linePos     = q.outPos;
  assign lineNeg     = q.outNeg;
  assign lineClock50 = q.clk50;

  // checks on the encoded stream

  sequence s_sym_out;
    q.outStrobe && singleRail && (q.outPos || q.outNeg);
  endsequence

  sequence s_reset_pulse;
    !rstn;
  endsequence

  a_reset_state: assert property (@(posedge clock)
    s_reset_pulse |=> (q.zeroRun == RUN_START) && (q.lastPol == POL_START)
                      && (q.markParity == PARITY_START))
    else $error("encoder state not cleared by reset");

  a_ami_alternate: assert property (@(posedge clock) disable iff (!rstn)
    s_sym_out ##0 !q.outViol |-> (q.outPos == !q.lastOutPol))
    else $error("ordinary mark did not alternate");

  a_viol_polarity: assert property (@(posedge clock) disable iff (!rstn)
    s_sym_out ##0 q.outViol |-> (q.outPos == q.lastOutPol))
    else $error("violation did not repeat previous polarity");

  a_odd_marks: assert property (@(posedge clock) disable iff (!rstn)
    s_sym_out ##0 q.outViol |-> q.outParity)
    else $error("even mark count between violations");

  a_b3zs_run: assert property (@(posedge clock) disable iff (!rstn)
    singleRail && (rate != TLC_RATE_E3) |-> q.zeroRun < RUN_B3ZS)
    else $error("three-zero run not substituted");

  a_hdb3_run: assert property (@(posedge clock) disable iff (!rstn)
    singleRail && (rate == TLC_RATE_E3) |-> q.zeroRun < RUN_HDB3)
    else $error("four-zero run not substituted");

  a_dual_bypass: assert property (@(posedge clock) disable iff (!rstn)
    tick && !singleRail && fifoValid |=> (linePos == $past(fifoData[1]))
                                     && (lineNeg == $past(fifoData[0])) && !q.outViol)
    else $error("dual rail data not forwarded");

  a_one_polarity: assert property (@(posedge clock) disable iff (!rstn)
    singleRail && q.outStrobe |-> !(linePos && lineNeg))
    else $error("both line polarities at once");

  a_fall_sample: assert property (@(posedge clock) disable iff (!rstn)
    clkFall |=> !q.pinStable[PIN_CLK] && $past(q.pinStable[PIN_CLK]))
    else $error("sample not on falling edge");

  a_clk_regen: assert property (@(posedge clock) disable iff (!rstn)
    clkFall |=> lineClock50 && (q.periodCnt == 8'h00))
    else $error("regenerated clock not restarted at fall");

  // line levels only move on a tick; downstream shaping relies on it
  sequence s_quiet_cycle;
    !tick;
  endsequence

  a_hold_levels: assert property (@(posedge clock) disable iff (!rstn)
    s_quiet_cycle |=> $stable(linePos) && $stable(lineNeg))
    else $error("line levels moved without a tick");

  // a data mark enters the window with the opposite polarity
  sequence s_mark_in;
    tick && singleRail && dataBit;
  endsequence

  a_mark_enters: assert property (@(posedge clock) disable iff (!rstn)
    s_mark_in |=> (q.lastPol != $past(q.lastPol))
                  && (q.slot[0] == {1'b0, q.lastPol, ~q.lastPol}))
    else $error("data mark did not flip polarity");

  // last zero of a run: the substitution is decided in this cycle
  sequence s_run_done;
    tick && singleRail && !dataBit && (q.zeroRun + 3'h1 == runLimit);
  endsequence

  a_sub_placed: assert property (@(posedge clock) disable iff (!rstn)
    s_run_done |=> q.slot[0][2] && (q.zeroRun == RUN_START)
                   && (q.markParity == PARITY_START))
    else $error("zero run left without a violation");

  a_b_inserted: assert property (@(posedge clock) disable iff (!rstn)
    s_run_done ##0 !q.markParity |=> (q.lastPol != $past(q.lastPol))
                                     && (q.slot[0][1] == q.lastPol))
    else $error("even mark count but no B pulse");

  a_no_b: assert property (@(posedge clock) disable iff (!rstn)
    s_run_done ##0 q.markParity |=> $stable(q.lastPol) && (q.slot[0][1] == q.lastPol))
    else $error("odd mark count but a B pulse was added");

  // a long measured period gives at least four high cycles after the fall
  sequence s_fall_long;
    clkFall && (q.periodCnt >= 8'h07);
  endsequence

  sequence s_half_high;
    lineClock50 [*4];
  endsequence

  a_clk_half: assert property (@(posedge clock) disable iff (!rstn)
    s_fall_long |=> s_half_high)
    else $error("regenerated clock high phase cut short");

  // a full fifo stays full until the line drains it; later falls are lost
  a_full_holds: assert property (@(posedge clock) disable iff (!rstn)
    !txReady && !tick |=> !txReady)
    else $error("fifo freed space without a drain");

endmodule
`default_nettype wire

// [tb/tlc_framer_model.sv]
`timescale 1ns/10ps
`default_nettype none
// terminal side: free-running line clock, one queued bit per period, zeros when idle; single rail drives negNoise on the negative line
module tlc_framer_model (
  input  wire logic       clock,
  input  wire logic [3:0] hiLen,
  input  wire logic [3:0] loLen,
  input  wire logic       dualRail,
  input  wire logic       negNoise,
  output logic            txLineClock,
  output logic            txPositiveData,
  output logic            txNegativeData
);
  logic posQ[$];
  logic negQ[$];
  logic p;
  logic n;
  // data moves at the rise so it is steady around the sampling fall
  initial begin
    txLineClock = 1'b1;
    txPositiveData = 1'b0;
    txNegativeData = 1'b0;
    forever begin
      repeat (hiLen) @(posedge clock);
      #1 txLineClock = 1'b0;
      repeat (loLen) @(posedge clock);
      #1 txLineClock = 1'b1;
      p = 1'b0;
      n = 1'b0;
      if (posQ.size() > 0) begin
        p = posQ.pop_front();
        n = negQ.pop_front();
      end
      txPositiveData = p;
      txNegativeData = dualRail ? n : negNoise;
    end
  end
endmodule
`default_nettype wire

// [tb/tx_line_code_encoder_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tx_line_code_encoder_tb import tlc_pkg::*;;
  logic       clock, rstn, railFormatSelect, hostRailCtrl, hostMode, lineEnable;
  logic [1:0] hwRateSelect, hostRateSelect;
  logic       txReady, linePos, lineNeg, lineClock50, codingActive;
  logic       txLineClock, txPositiveData, txNegativeData, dualRail, negNoise;
  logic [3:0] hiLen, loLen;
  logic [1:0] sym[$], pat[$];
  int         mismatches, numChecks;

  tlc_encoder u_tlc_encoder (.clock(clock), .rstn(rstn), .txLineClock(txLineClock),
    .txPositiveData(txPositiveData), .txNegativeData(txNegativeData),
    .railFormatSelect(railFormatSelect), .hostRailCtrl(hostRailCtrl), .hostMode(hostMode),
    .hwRateSelect(hwRateSelect), .hostRateSelect(hostRateSelect), .lineEnable(lineEnable),
    .txReady(txReady), .linePos(linePos), .lineNeg(lineNeg), .lineClock50(lineClock50),
    .codingActive(codingActive));
  tlc_framer_model u_tlc_framer_model (.clock(clock), .hiLen(hiLen), .loLen(loLen),
    .dualRail(dualRail), .negNoise(negNoise), .txLineClock(txLineClock),
    .txPositiveData(txPositiveData), .txNegativeData(txNegativeData));

  always #2.5 clock = ~clock;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    tick(4);
    check("outputs in reset", 3'b001, {linePos, lineNeg, txReady});
    rstn = 1'b1;
    // synchronisers refill from reset before the mode pins read true
    tick(4);
  endtask

  // expected symbols {pos,neg}, msb first; also queued at the terminal side when send is set
  task automatic push(logic [31:0] p, logic [31:0] n, int len, bit send);
    pat.delete();
    for (int b = len - 1; b >= 0; b--) begin
      pat.push_back({p[b], n[b]});
      if (send) u_tlc_framer_model.posQ.push_back(p[b]);
      if (send) u_tlc_framer_model.negQ.push_back(n[b]);
    end
  endtask

  // one symbol per line period, taken while the outputs stand
  task automatic capture(int n);
    sym.delete();
    repeat (n) begin
      @(posedge txLineClock);
      sym.push_back({linePos, lineNeg});
      check("both rails high", 0, linePos & lineNeg);
    end
  endtask

  function automatic bit found(logic [1:0] s[$]);
    bit ok;
    for (int i = 0; i + pat.size() <= s.size(); i++) begin
      ok = 1;
      foreach (pat[j]) if (s[i+j] !== pat[j]) ok = 0;
      if (ok) return 1;
    end
    return 0;
  endfunction

  // decodes the line stream, judging every substitution on the way
  task automatic verify(int run);
    logic [1:0] dec[$];
    int         zeros, marks, seen, lastV;
    logic       p, lastP;
    zeros = 0;
    marks = 0;
    seen = 0;
    lastV = 0;
    lastP = 1'b0;
    foreach (sym[i]) begin
      if (sym[i] == 2'b00) begin
        zeros++;
        // reset leaves idle zeros in the window ahead of the first pulse
        if (seen != 0) check("zero run", 1, zeros < run);
        dec.push_back(2'b00);
      end else begin
        zeros = 0;
        p = sym[i][1];
        if (seen == 0) check("first mark polarity", 1, p);
        if (seen != 0 && p == lastP) begin
          check("violation window", 0, {sym[i-1], (run == 4) ? sym[i-2] : 2'b00});
          if (lastV != 0) check("marks between violations", 1, marks % 2);
          lastV = 1;
          marks = 0;
          for (int k = 1; k < run; k++) dec[dec.size()-k] = 2'b00;
          dec.push_back(2'b00);
        end else begin
          marks++;
          dec.push_back(2'b10);
        end
        lastP = p;
        seen = 1;
      end
    end
    check("decoded data", 1, found(dec));
  endtask

  task automatic run_coded(logic hm, logic [1:0] rate, logic [1:0] other, int run,
                           logic [3:0] hi);
    int highs;
    {hostMode, hostRailCtrl, railFormatSelect} = {hm, hm, !hm};
    hwRateSelect = hm ? other : rate;
    hostRateSelect = hm ? rate : other;
    {dualRail, negNoise, hiLen, loLen} = {1'b0, hm, hi, 4'ha - hi};
    do_reset();
    check("coding active", 1, codingActive);
    fork
      capture(80);
      begin
        repeat (3) @(posedge txLineClock);
        push(32'h8890_4215, 0, 32, 1);
      end
    join
    verify(run);
    highs = 0;
    repeat (10) begin
      tick(1);
      highs += lineClock50;
    end
    check("regenerated high time", 1, highs >= 4 && highs <= 6);
  endtask

  task automatic rail_table();
    for (int i = 0; i < 8; i++) begin
      {hostMode, railFormatSelect, hostRailCtrl} = i[2:0];
      tick(8);
      check("coding active", hostMode ? hostRailCtrl : railFormatSelect, codingActive);
    end
  endtask

  task automatic wait_ready(logic v);
    for (int n = 0; n < 400 && txReady !== v; n++) tick(1);
    check("txReady", v, txReady);
    if (txReady !== v) tally_and_finish();
  endtask

  // dual rail: straight pass, then a full fifo with the line stalled
  task automatic run_dual();
    {hostMode, railFormatSelect, dualRail, hiLen, loLen} = {2'b00, 1'b1, 4'h5, 4'h5};
    do_reset();
    check("coding active", 0, codingActive);
    fork
      capture(40);
      push(16'h920C, 16'h4002, 16, 1);
    join
    check("dual rail symbols", 1, found(sym));
    @(negedge txLineClock);
    lineEnable = 1'b0;
    push(10'h2DB, 10'h124, 10, 1);
    wait_ready(1'b0);
    repeat (12) @(posedge txLineClock);
    lineEnable = 1'b1;
    wait_ready(1'b1);
    capture(20);
    push(10'h2D8, 10'h120, 10, 0);
    check("symbols after stall", 1, found(sym));
  endtask

  initial begin
    {clock, rstn, railFormatSelect, hostRailCtrl, hostMode, lineEnable} = 6'b000001;
    {hwRateSelect, hostRateSelect, dualRail, negNoise} = 6'h00;
    {hiLen, loLen} = 8'h55;
    mismatches = 0;
    numChecks = 0;
    do_reset();
    rail_table();
    run_coded(1'b0, TLC_RATE_E3, TLC_RATE_DS3, 4, 4'h5);
    run_coded(1'b1, TLC_RATE_DS3, TLC_RATE_E3, 3, 4'h3);
    run_coded(1'b0, TLC_RATE_STS1, TLC_RATE_E3, 3, 4'h7);
    run_coded(1'b1, TLC_RATE_SPARE, TLC_RATE_E3, 3, 4'h5);
    run_dual();
    tally_and_finish();
  end
endmodule
`default_nettype wire
